// *** core/nrf_pkg.sv ***
package nrf_pkg;

    // register byte addresses
    localparam logic [11:0] NRF_ASYNC_LOW_SET   = 12'h108;
    localparam logic [11:0] NRF_ASYNC_LOW_CLEAR = 12'h10C;
    localparam logic [11:0] NRF_PHYS_HIGH_SET   = 12'h110;
    localparam logic [11:0] NRF_PHYS_HIGH_CLEAR = 12'h114;

    localparam logic [31:0] NRF_FILTER_RESET  = 32'h0000_0000;
    localparam int          NRF_ALL_BUSES_BIT = 31;
    localparam logic [5:0]  NRF_HIGH_BASE     = 6'h20;
    localparam logic [9:0]  NRF_LOCAL_BUS     = 10'h3FF;

    typedef enum logic [1:0] {
        NRF_DEST_DROP,
        NRF_DEST_ASYNC,
        NRF_DEST_PHYS
    } nrf_dest_t;

    // incoming request as seen by the receive filter
    typedef struct packed {
        logic       valid;
        logic [9:0] src_bus;
        logic [5:0] src_node;
        logic       phys_bound;
    } nrf_req_t;

    // filter verdict
    typedef struct packed {
        logic      valid;
        logic      ack;
        nrf_dest_t dest;
    } nrf_verdict_t;

endpackage

// *** core/nrf_decide.sv ***
module nrf_decide
    import nrf_pkg::*;
(
    // request in
    input  wire nrf_req_t     req,
    input  wire logic [9:0]   local_bus,
    // filters
    input  wire logic [31:0]  async_low,
    input  wire logic [31:0]  async_high,
    input  wire logic [31:0]  phys_low,
    input  wire logic [31:0]  phys_high,
    // verdict out
    output nrf_verdict_t      verdict
);

    function automatic logic node_bit(input logic [31:0] low, input logic [31:0] high,
                                      input logic [5:0] node);
        if (node < NRF_HIGH_BASE)
            node_bit = low[node[4:0]];
        else if (node == 6'h3F)
            node_bit = 1'b0;
        else
            node_bit = high[node[4:0]];
    endfunction

    logic local_src;
    logic async_ok;
    logic phys_ok;

    always_comb begin
        local_src = (req.src_bus == NRF_LOCAL_BUS) || (req.src_bus == local_bus);
        // node compare only on the own bus; remote buses pass via bit 31
        if (local_src) begin
            async_ok = node_bit(async_low, async_high, req.src_node); // [RULE_01] [RULE_02] [RULE_07]
            phys_ok  = node_bit(phys_low, phys_high, req.src_node);   // [RULE_10]
        end else begin
            async_ok = phys_high[NRF_ALL_BUSES_BIT];                  // [RULE_08]
            phys_ok  = phys_high[NRF_ALL_BUSES_BIT];
        end
        verdict.valid = req.valid;
        verdict.ack   = req.valid && async_ok;                        // [RULE_11]
        if (!async_ok)
            verdict.dest = NRF_DEST_DROP;                             // [RULE_11]
        else if (req.phys_bound && phys_ok)
            verdict.dest = NRF_DEST_PHYS;                             // [RULE_05]
        else
            verdict.dest = NRF_DEST_ASYNC;                            // [RULE_06]
    end

endmodule

// *** core/nrf_filter.sv ***
// How it works
// [RULE_01] Bit n of the low async filter accepts async requests from local node n, 0 to 31.
// [RULE_02] The low async filter behaves exactly like the high one, only for low node ids.
// [RULE_03] The low async filter has set and clear locations, ones set or clear, both read it.
// [RULE_04] The high physical filter has set and clear locations with the same semantics.
// [RULE_05] A physical-bound packet passes the async filter first, then the physical filter.
// [RULE_06] A zero physical bit sends the request to the async receive request context.
// [RULE_07] Per-node bits are compared only when the source is on the controller's bus.
// [RULE_08] Remote-bus packets are not acknowledged unless high physical bit 31 is one.
// [RULE_09] High physical bit 31 survives a serial bus reset; other bits need not.
// [RULE_10] High physical bits 30..0 enable physical handling for nodes 62..32.
// [RULE_11] A zero async bit for a local source means no acknowledge and no queueing.
// [RULE_12] Zero bits written leave filter bits alone, and both filters reset to zero.
module nrf_filter
    import nrf_pkg::*;
(
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    // apb slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr,
    // link side
    input  wire logic         serial_bus_reset,
    input  wire logic [9:0]   local_bus_id,
    input  wire logic [31:0]  async_filter_high,
    input  wire logic [31:0]  phys_filter_low,
    input  wire nrf_req_t     req_in,
    // filter results
    output nrf_verdict_t      verdict_out,
    output logic [31:0]       async_low_out,
    output logic [31:0]       phys_high_out
);

    typedef struct packed {
        logic [31:0]  async_low;
        logic [31:0]  phys_high;
        logic         pready;
        logic [31:0]  prdata;
        logic         pslverr;
        nrf_verdict_t verdict;
    } nrf_state_t;

    logic [1:0] rst_sync;
    logic       rst_n;
    nrf_state_t cur;
    nrf_state_t next_cur;
    nrf_verdict_t dec;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == NRF_ASYNC_LOW_SET) || (a == NRF_ASYNC_LOW_CLEAR) ||
                   (a == NRF_PHYS_HIGH_SET) || (a == NRF_PHYS_HIGH_CLEAR);
    endfunction

    nrf_decide u_decide (
        .req        (req_in),
        .local_bus  (local_bus_id),
        .async_low  (cur.async_low),
        .async_high (async_filter_high),
        .phys_low   (phys_filter_low),
        .phys_high  (cur.phys_high),
        .verdict    (dec)
    );

    logic setup;
    logic wr;

    always_comb begin
        next_cur = cur;
        setup    = psel && !penable && !cur.pready;
        wr       = psel && penable && cur.pready && pwrite;
        // no wait state: answer in the first access cycle
        next_cur.pready  = setup;
        next_cur.pslverr = setup && !addr_hit(paddr);
        next_cur.prdata  = 32'h0000_0000;
        if (setup && !pwrite) begin
            case (paddr)
                NRF_ASYNC_LOW_SET,
                NRF_ASYNC_LOW_CLEAR: next_cur.prdata = cur.async_low;  // [RULE_03]
                NRF_PHYS_HIGH_SET,
                NRF_PHYS_HIGH_CLEAR: next_cur.prdata = cur.phys_high;  // [RULE_04]
                default:             next_cur.prdata = 32'h0000_0000;
            endcase
        end
        if (serial_bus_reset) begin
            next_cur.async_low = NRF_FILTER_RESET;
            next_cur.phys_high = cur.phys_high &
                                 (32'h0000_0001 << NRF_ALL_BUSES_BIT); // [RULE_09]
        end
        if (wr) begin
            case (paddr)
                NRF_ASYNC_LOW_SET:   next_cur.async_low = next_cur.async_low | pwdata;  // [RULE_03] [RULE_12]
                NRF_ASYNC_LOW_CLEAR: next_cur.async_low = next_cur.async_low & ~pwdata; // [RULE_03] [RULE_12]
                NRF_PHYS_HIGH_SET:   next_cur.phys_high = next_cur.phys_high | pwdata;  // [RULE_04] [RULE_12]
                NRF_PHYS_HIGH_CLEAR: next_cur.phys_high = next_cur.phys_high & ~pwdata; // [RULE_04] [RULE_12]
                default:             next_cur.async_low = next_cur.async_low;
            endcase
        end
        next_cur.verdict = dec;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            cur <= '0; // [RULE_12]
        else
            cur <= next_cur;
    end

    assign pready        = cur.pready;
    assign prdata        = cur.prdata;
    assign pslverr       = cur.pslverr;
    assign verdict_out   = cur.verdict;
    assign async_low_out = cur.async_low;
    assign phys_high_out = cur.phys_high;

    remote_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_08]
        (req_in.valid && req_in.src_bus != NRF_LOCAL_BUS && req_in.src_bus != local_bus_id
         && !cur.phys_high[31]) |=> !verdict_out.ack)
        else $error("remote request acknowledged without all-buses bit");

    async_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_11]
        (req_in.valid && req_in.src_bus == local_bus_id && req_in.src_node < 6'h20
         && !cur.async_low[req_in.src_node[4:0]]) |=> verdict_out.dest == NRF_DEST_DROP)
        else $error("disabled local node not dropped");

    phys_route_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_06]
        (req_in.valid && req_in.phys_bound && req_in.src_bus == local_bus_id
         && req_in.src_node >= 6'h20 && req_in.src_node < 6'h3F
         && !cur.phys_high[req_in.src_node[4:0]]) |=> verdict_out.dest != NRF_DEST_PHYS)
        else $error("physical route despite clear bit");

    phys_accept_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_10]
        (req_in.valid && req_in.phys_bound && req_in.src_bus == local_bus_id
         && req_in.src_node >= 6'h20 && req_in.src_node < 6'h3F
         && async_filter_high[req_in.src_node[4:0]]
         && cur.phys_high[req_in.src_node[4:0]]) |=> verdict_out.dest == NRF_DEST_PHYS)
        else $error("enabled node not routed physical");

    keep_all_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_09]
        (serial_bus_reset && !(psel && penable && pwrite && pready))
        |=> cur.phys_high[31] == $past(cur.phys_high[31]))
        else $error("all-buses bit lost on bus reset");

    set_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_03]
        (psel && penable && pready && pwrite && paddr == NRF_ASYNC_LOW_SET && !serial_bus_reset)
        |=> cur.async_low == ($past(cur.async_low) | $past(pwdata)))
        else $error("low set write wrong");

    clear_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_04]
        (psel && penable && pready && pwrite && paddr == NRF_PHYS_HIGH_CLEAR
         && !serial_bus_reset) |=> cur.phys_high == ($past(cur.phys_high) & ~$past(pwdata)))
        else $error("high clear write wrong");

    read_back_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_03]
        (psel && !penable && !pwrite && !pready && paddr == NRF_ASYNC_LOW_CLEAR)
        |=> pready && prdata == $past(cur.async_low))
        else $error("low filter read back wrong");

endmodule

// *** test/nrf_node_model.sv ***
module nrf_node_model
    import nrf_pkg::*;
(
    // clock
    input  wire logic sys_clk,
    // request out
    output nrf_req_t  req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial req = '0;
    // one request per call; fields flip afterwards so stale values never pass as valid
    task automatic send(input logic [9:0] bus, input logic [5:0] node, input logic phys);
        req <= '{1'b1, bus, node, phys};
        @(posedge sys_clk);
        req <= '{1'b0, ~bus, ~node, ~phys};
    endtask
endmodule

// *** test/tb_top.sv ***
module tb_top
    import nrf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic         sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic         serial_bus_reset = 0, pready, pslverr, er;
    logic [11:0]  paddr = '0;
    logic [31:0]  pwdata = '0, prdata, rd, alo, phi;
    logic [31:0]  afh = 32'h0000_0003, pfl = 32'h0000_0100;
    logic [9:0]   local_bus_id = 10'h005;
    nrf_req_t     req;
    nrf_verdict_t verdict;
    int           errors = 0, total_checks = 0, cycles = 0;

    nrf_node_model node (.sys_clk(sys_clk), .req(req));
    nrf_filter dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .serial_bus_reset(serial_bus_reset), .local_bus_id(local_bus_id),
        .async_filter_high(afh), .phys_filter_low(pfl), .req_in(req),
        .verdict_out(verdict), .async_low_out(alo), .phys_high_out(phi));

    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkv(input nrf_verdict_t got, input nrf_verdict_t exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: verdict %b expected %b", $time, got, exp);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // sampled at the edge: values seen are those that stood before it
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    task automatic rq(input logic [9:0] b, input logic [5:0] n, input logic p,
                      input logic ack, input nrf_dest_t dest);
        node.send(b, n, p);
        // verdict registered at the send edge stands until the next one
        @(posedge sys_clk);
        chkv(verdict, '{1'b1, ack, dest});
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rdc(NRF_ASYNC_LOW_SET, NRF_FILTER_RESET);
        rdc(NRF_PHYS_HIGH_CLEAR, NRF_FILTER_RESET);
        apb(1'b1, NRF_ASYNC_LOW_SET, 32'hA5A5_0F0F);
        apb(1'b1, NRF_ASYNC_LOW_CLEAR, 32'h0000_000F);
        rdc(NRF_ASYNC_LOW_SET, 32'hA5A5_0F00);
        rdc(NRF_ASYNC_LOW_CLEAR, 32'hA5A5_0F00);
        apb(1'b1, NRF_PHYS_HIGH_SET, 32'h8000_0003);
        apb(1'b1, NRF_PHYS_HIGH_CLEAR, 32'h0000_0001);
        rdc(NRF_PHYS_HIGH_CLEAR, 32'h8000_0002);
        chk(phi, 32'h8000_0002);
        apb(1'b1, 12'h120, 32'hFFFF_FFFF);
        chk({31'h0, er}, 32'h0000_0001);
        chk(alo, 32'hA5A5_0F00);
        rq(10'h005, 6'd0, 1'b0, 1'b0, NRF_DEST_DROP);
        rq(10'h005, 6'd8, 1'b0, 1'b1, NRF_DEST_ASYNC);
        rq(10'h005, 6'd8, 1'b1, 1'b1, NRF_DEST_PHYS);
        rq(10'h005, 6'd9, 1'b1, 1'b1, NRF_DEST_ASYNC);
        rq(10'h005, 6'd0, 1'b1, 1'b0, NRF_DEST_DROP);
        rq(10'h005, 6'd33, 1'b1, 1'b1, NRF_DEST_PHYS);
        rq(10'h005, 6'd32, 1'b1, 1'b1, NRF_DEST_ASYNC);
        rq(10'h005, 6'd34, 1'b0, 1'b0, NRF_DEST_DROP);
        rq(10'h007, 6'd0, 1'b0, 1'b1, NRF_DEST_ASYNC);
        rq(10'h3FF, 6'd8, 1'b0, 1'b1, NRF_DEST_ASYNC);
        serial_bus_reset <= 1'b1;
        @(posedge sys_clk);
        serial_bus_reset <= 1'b0;
        @(posedge sys_clk);
        rdc(NRF_ASYNC_LOW_SET, NRF_FILTER_RESET);
        rdc(NRF_PHYS_HIGH_SET, 32'h8000_0000);
        apb(1'b1, NRF_PHYS_HIGH_CLEAR, 32'h8000_0000);
        rq(10'h007, 6'd0, 1'b0, 1'b0, NRF_DEST_DROP);
        final_report();
    end
endmodule
